/* File: hw/lsp_slave.sv */
`timescale 1ns/1ns
`include "lsp_params.svh"

// Overview of operation
// - first bit high requests a read
// - first bit low requests a write
// - read: second bit high data, low status
// - write: second bit high data, low status
// - read payload out MSB first after select
// - read status: low new, high stale
// - write status: low accepted, high buffer full

module lsp_slave #(
  parameter int DATA_W = `LSP_DATA_W
) (
  // system clock and reset
  input  wire logic              clk_sys_i,
  input  wire logic              nrst_i,
  // serial pins, host side
  input  wire logic              sclk_i,
  input  wire logic              ss_i,
  input  wire logic              mosi_i,
  output logic                   miso_o,
  output logic                   miso_oe_o,
  // read data source
  input  wire logic [DATA_W-1:0] tx_data_i,
  input  wire logic              tx_valid_i,
  output logic                   tx_taken_o,
  // read status source
  input  wire logic [DATA_W-1:0] status_i,
  // receive buffer sink
  output logic [DATA_W-1:0]      rx_data_o,
  output logic                   rx_valid_o,
  input  wire logic              rx_ready_i,
  // status register write
  output logic                   stat_wr_o
);
  import lsp_pkg::*;

  localparam int CNT_W = $clog2(DATA_W + 1);

  // elaboration check: both shift registers need at least two payload bits
  if (DATA_W < 2) begin : g_bad_width
    $error("lsp_slave: DATA_W must be at least 2");
  end

  ////////////////////////////////////////////////////////////////////////////
  // pin synchronisers

  logic [2:0] pin_raw;
  logic [2:0] pin_s1;
  logic [2:0] pin_s2;
  logic [2:0] pin_s3;
  logic [2:0] pin_q;

  assign pin_raw[LSP_PIN_SCLK] = sclk_i;
  assign pin_raw[LSP_PIN_SS]   = ss_i;
  assign pin_raw[LSP_PIN_MOSI] = mosi_i;

  // four flops per pin; a level counts once stages two and three agree
  for (genvar i = 0; i < $bits(pin_raw); i++) begin : g_sync
    always_ff @(posedge clk_sys_i or negedge nrst_i) begin
      if (!nrst_i) begin
        pin_s1[i] <= `LSP_PIN_RST;
        pin_s2[i] <= `LSP_PIN_RST;
        pin_s3[i] <= `LSP_PIN_RST;
        pin_q[i]  <= `LSP_PIN_RST;
      end else begin
        pin_s1[i] <= pin_raw[i];
        pin_s2[i] <= pin_s1[i];
        pin_s3[i] <= pin_s2[i];
        if (pin_s2[i] == pin_s3[i]) begin
          pin_q[i] <= pin_s3[i];  // filters a single-cycle glitch
        end
      end
    end
  end

  logic sclk_prev;
  logic sclk_rise;
  logic sclk_fall;
  logic frame;
  logic mosi;

  // serial clock edge detection on the clean level
  always_ff @(posedge clk_sys_i or negedge nrst_i) begin
    if (!nrst_i) begin
      sclk_prev <= `LSP_PIN_RST;
    end else begin
      sclk_prev <= pin_q[LSP_PIN_SCLK];
    end
  end

  assign sclk_rise = pin_q[LSP_PIN_SCLK] & ~sclk_prev;
  assign sclk_fall = ~pin_q[LSP_PIN_SCLK] & sclk_prev;
  assign frame     = pin_q[LSP_PIN_SS];       // frame select is active high
  assign mosi      = pin_q[LSP_PIN_MOSI];

  ////////////////////////////////////////////////////////////////////////////
  // frame sequencer

  lsp_phase_t       phase;
  lsp_phase_t       next_phase;
  logic [CNT_W-1:0] pay_cnt;
  logic             last_pay;

  assign last_pay = (pay_cnt == CNT_W'(DATA_W - 1));

  // next phase on each rising serial clock edge
  always_comb begin
    next_phase = phase;
    unique case (phase)
      LSP_IDLE:    next_phase = LSP_DIR;
      LSP_DIR:     next_phase = LSP_SEL;
      LSP_SEL:     next_phase = LSP_PAYLOAD;
      LSP_PAYLOAD: next_phase = last_pay ? LSP_STATUS : LSP_PAYLOAD;
      LSP_STATUS:  next_phase = LSP_TAIL;
      LSP_TAIL:    next_phase = LSP_TAIL;  // extra clocks ignored until select drops
    endcase
  end

  // phase holds the bit that the next rising edge will sample
  always_ff @(posedge clk_sys_i or negedge nrst_i) begin
    if (!nrst_i) begin
      phase <= LSP_IDLE;
    end else if (!frame) begin
      phase <= LSP_IDLE;                    // select low restarts the frame
    end else if (phase == LSP_IDLE) begin
      phase <= LSP_DIR;
    end else if (sclk_rise) begin
      phase <= next_phase;
    end
  end

  // payload bit counter
  always_ff @(posedge clk_sys_i or negedge nrst_i) begin
    if (!nrst_i) begin
      pay_cnt <= '0;
    end else if (!frame || phase != LSP_PAYLOAD) begin
      pay_cnt <= '0;
    end else if (sclk_rise) begin
      pay_cnt <= pay_cnt + CNT_W'(1);
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // header decode

  logic is_read;
  logic is_data;

  // direction then register select, sampled on rising edges
  always_ff @(posedge clk_sys_i or negedge nrst_i) begin
    if (!nrst_i) begin
      is_read <= 1'b0;
      is_data <= 1'b0;
    end else if (sclk_rise && frame) begin
      if (phase == LSP_DIR) begin
        is_read <= (mosi == `LSP_DIR_READ);
      end
      if (phase == LSP_SEL) begin
        is_data <= (mosi == `LSP_SEL_DATA);
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // read path

  logic [DATA_W-1:0] out_sr;
  logic              stale;

  // read source latched at the select bit, shifted out MSB first
  always_ff @(posedge clk_sys_i or negedge nrst_i) begin
    if (!nrst_i) begin
      out_sr <= '0;
      stale  <= `LSP_STAT_OK;
    end else if (frame && sclk_rise && phase == LSP_SEL) begin
      out_sr <= (mosi == `LSP_SEL_DATA) ? tx_data_i : status_i;
      // status register is always current; data is stale with no new byte
      stale  <= (mosi == `LSP_SEL_DATA) && !tx_valid_i;
    end else if (frame && sclk_fall && phase == LSP_PAYLOAD) begin
      out_sr <= {out_sr[DATA_W-2:0], 1'b0};
    end
  end

  // consume the data byte once its last bit has gone out
  always_ff @(posedge clk_sys_i or negedge nrst_i) begin
    if (!nrst_i) begin
      tx_taken_o <= 1'b0;
    end else begin
      tx_taken_o <= frame && sclk_rise && phase == LSP_PAYLOAD && last_pay
                    && is_read && is_data && !stale;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // write path

  logic [DATA_W-1:0] in_sr;
  logic [DATA_W-1:0] next_byte;
  logic              full;

  assign next_byte = {in_sr[DATA_W-2:0], mosi};

  // payload shifts in MSB first on rising edges
  always_ff @(posedge clk_sys_i or negedge nrst_i) begin
    if (!nrst_i) begin
      in_sr <= '0;
    end else if (frame && sclk_rise && phase == LSP_PAYLOAD) begin
      in_sr <= next_byte;
    end
  end

  // hand over the byte; a full buffer rejects it and flags a retry
  always_ff @(posedge clk_sys_i or negedge nrst_i) begin
    if (!nrst_i) begin
      rx_data_o  <= '0;
      rx_valid_o <= 1'b0;
      stat_wr_o  <= 1'b0;
      full       <= `LSP_STAT_OK;
    end else begin
      rx_valid_o <= 1'b0;
      stat_wr_o  <= 1'b0;
      if (frame && sclk_rise && phase == LSP_PAYLOAD && last_pay && !is_read) begin
        if (is_data) begin
          // a rejected byte leaves the last accepted one on the output
          if (rx_ready_i) begin
            rx_data_o <= next_byte;
          end
          rx_valid_o <= rx_ready_i;
          full       <= rx_ready_i ? `LSP_STAT_OK : `LSP_STAT_RETRY;
        end else begin
          rx_data_o  <= next_byte;
          stat_wr_o  <= 1'b1;
          full       <= `LSP_STAT_OK;
        end
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // serial output

  // driven on falling edges so it is settled for the host's rising edge
  always_ff @(posedge clk_sys_i or negedge nrst_i) begin
    if (!nrst_i) begin
      miso_o <= `LSP_MISO_IDLE;
    end else if (!frame) begin
      miso_o <= `LSP_MISO_IDLE;
    end else if (sclk_fall) begin
      if (phase == LSP_PAYLOAD) begin
        miso_o <= is_read ? out_sr[DATA_W-1] : `LSP_MISO_IDLE;
      end else if (phase == LSP_STATUS) begin
        miso_o <= is_read ? stale : full;
      end
    end
  end

  // pin is driven only inside a frame
  always_ff @(posedge clk_sys_i or negedge nrst_i) begin
    if (!nrst_i) begin
      miso_oe_o <= 1'b0;
    end else begin
      miso_oe_o <= frame;
    end
  end

endmodule // lsp_slave

/* File: include/lsp_params.svh */
`ifndef LSP_PARAMS_SVH
`define LSP_PARAMS_SVH

// payload width of one transaction
`define LSP_DATA_W      8
// direction and register-select bits ahead of the payload
`define LSP_HEAD_BITS   2
// status bit plus trailing clock after the payload
`define LSP_TAIL_BITS   2
// direction bit value for a read
`define LSP_DIR_READ    1'b1
// register-select value for the data register
`define LSP_SEL_DATA    1'b1
// status bit values
`define LSP_STAT_OK     1'b0
`define LSP_STAT_RETRY  1'b1
// pin synchroniser idle level
`define LSP_PIN_RST     1'b0
// serial output level outside a frame
`define LSP_MISO_IDLE   1'b0

`endif

/* File: include/lsp_pkg.sv */
package lsp_pkg;

  // position of the serial bit stream within a frame
  typedef enum logic [2:0] {
    LSP_IDLE,
    LSP_DIR,
    LSP_SEL,
    LSP_PAYLOAD,
    LSP_STATUS,
    LSP_TAIL
  } lsp_phase_t;

  // pin index inside the synchroniser bank
  typedef enum int {
    LSP_PIN_SCLK = 0,
    LSP_PIN_SS   = 1,
    LSP_PIN_MOSI = 2
  } lsp_pin_t;

endpackage

/* File: tb/lsp_slave_properties.sv */
`timescale 1ns/1ns
module lsp_props #(
  parameter int DATA_W = 8
) (
  // clock and reset
  input wire logic              clk_sys_i,
  input wire logic              nrst_i,
  // watched ports
  input wire logic              ss_i,
  input wire logic              miso_o,
  input wire logic              miso_oe_o,
  input wire logic              tx_valid_i,
  input wire logic              tx_taken_o,
  input wire logic [DATA_W-1:0] rx_data_o,
  input wire logic              rx_valid_o,
  input wire logic              rx_ready_i,
  input wire logic              stat_wr_o
);
  default clocking @(posedge clk_sys_i); endclocking
  default disable iff (!nrst_i);
  // select seen low long enough must release the pin
  oe_idle_a: assert property (!ss_i [*8] |-> !miso_oe_o) else $error("oe outside frame");
  miso_idle_a: assert property (!miso_oe_o |-> !miso_o) else $error("miso outside frame");
  rx_pulse_a: assert property (rx_valid_o |=> !rx_valid_o) else $error("rx pulse long");
  stat_pulse_a: assert property (stat_wr_o |=> !stat_wr_o) else $error("stat pulse long");
  one_effect_a: assert property ($onehot0({rx_valid_o, stat_wr_o, tx_taken_o}))
    else $error("two effects at once");
  rxd_hold_a: assert property ($changed(rx_data_o) |-> rx_valid_o || stat_wr_o)
    else $error("rx data moved");
  // bench holds ready and valid steady across a frame
  full_block_a: assert property (rx_valid_o |-> $past(rx_ready_i)) else $error("full accepted");
  stale_pop_a: assert property (tx_taken_o |-> $past(tx_valid_i)) else $error("stale popped");
  cover property (rx_valid_o);
  cover property (stat_wr_o);
  cover property (tx_taken_o);
endmodule // lsp_props

bind lsp_slave lsp_props #(.DATA_W(DATA_W)) lsp_props_i (.*);

/* File: tb/lsp_host_model.sv */
`timescale 1ns/1ns
module lsp_host_model (
  // clock
  input  wire logic clk_sys_i,
  // serial pins
  output logic      sclk_o,
  output logic      ss_o,
  output logic      mosi_o,
  input  wire logic miso_i
);
  // clock idles low between frames
  initial begin
    sclk_o = 1'b0;
    ss_o = 1'b0;
    mosi_o = 1'b0;
  end

  // ten clk per half period so miso has settled before sampling
  task automatic xfer(input logic [9:0] tx, output logic [7:0] rd, output logic st);
    ss_o <= 1'b1;
    for (int i = 0; i < 12; i++) begin
      mosi_o <= (i < 10) ? tx[9-i] : ~mosi_o;
      repeat (10) @(posedge clk_sys_i);
      sclk_o <= 1'b1;
      if (i > 1 && i < 10) rd[9-i] = miso_i;
      if (i == 10) st = miso_i;
      repeat (10) @(posedge clk_sys_i);
      sclk_o <= 1'b0;
    end
    repeat (10) @(posedge clk_sys_i);
    ss_o <= 1'b0;
    mosi_o <= ~mosi_o;
    // select low for one full serial clock period before the next frame
    repeat (20) @(posedge clk_sys_i);
  endtask
endmodule // lsp_host_model

/* File: tb/tb_lsp_slave.sv */
`timescale 1ns/1ns
module tb_lsp_slave;
  logic       clk_sys_i = 1'b0;
  logic       nrst_i = 1'b0;
  logic       sclk, ss, mosi, miso, tx_taken, rx_valid, stat_wr, st;
  logic       miso_oe, miso_pin;
  logic [7:0] exp_q[$];
  logic       tx_valid = 1'b0;
  logic       rx_ready = 1'b0;
  logic [7:0] tx_data = 8'h00;
  logic [7:0] status = 8'h00;
  logic [7:0] rx_data, last, rd, pay;
  logic [1:0] m;
  int         mismatches = 0;
  int         n_compared = 0;
  int         n_rx, n_st, n_tk;

  always #4 clk_sys_i = ~clk_sys_i;

  // released line shows the inverse, so a late enable spoils the sample
  assign miso_pin = miso_oe ? miso : ~miso;

  lsp_host_model lsp_host_model_i (.clk_sys_i(clk_sys_i), .sclk_o(sclk), .ss_o(ss),
    .mosi_o(mosi), .miso_i(miso_pin));
  lsp_slave lsp_slave_i (.clk_sys_i(clk_sys_i), .nrst_i(nrst_i), .sclk_i(sclk), .ss_i(ss),
    .mosi_i(mosi), .miso_o(miso), .miso_oe_o(miso_oe),
    .tx_data_i(tx_data), .tx_valid_i(tx_valid),
    .tx_taken_o(tx_taken), .status_i(status), .rx_data_o(rx_data), .rx_valid_o(rx_valid),
    .rx_ready_i(rx_ready), .stat_wr_o(stat_wr));

  ////////////////////////////////////////////////////////////////////////////////
  task automatic chk_byte(input logic [7:0] g, input logic [7:0] e);
    n_compared++;
    if (g !== e) begin
      mismatches++;
      $display("Error %0t byte %h expected %h", $time, g, e);
    end
  endtask

  task automatic chk_bit(input logic g, input logic e);
    n_compared++;
    if (g !== e) begin
      mismatches++;
      $display("Error %0t status %b expected %b", $time, g, e);
    end
  endtask

  task automatic test_done;
    if (mismatches == 0 && n_compared > 0)
      $display("ALL TESTS PASSED");
    else
      $display("TESTS FAILED");
    $finish;
  endtask

  // count one-cycle effects, keep the byte they carried
  always @(posedge clk_sys_i) begin
    if (rx_valid || stat_wr) last = rx_data;
    if ((rx_valid || stat_wr) && exp_q.size() > 0) chk_byte(rx_data, exp_q.pop_front());
    if (rx_valid) n_rx++;
    if (stat_wr) n_st++;
    if (tx_taken) n_tk++;
  end

  // a frame is ~270 clk; margin for 24 frames plus a retry of each
  initial begin
    #200000;
    mismatches++;
    test_done;
  end

  ////////////////////////////////////////////////////////////////////////////////
  initial begin
    void'($urandom(32'hC6B617ED));
    repeat (4) @(posedge clk_sys_i);
    nrst_i <= 1'b1;
    repeat (10) @(posedge clk_sys_i);
    // low two index bits walk all four direction/select codes
    for (int i = 0; i < 24; i++) begin
      m = i[1:0];
      pay = 8'($urandom);
      tx_data <= 8'($urandom);
      status <= 8'($urandom);
      tx_valid <= 1'($urandom);
      rx_ready <= 1'($urandom);
      @(posedge clk_sys_i);
      n_rx = 0;
      n_st = 0;
      n_tk = 0;
      if (!m[1] && (!m[0] || rx_ready)) exp_q.push_back(pay);
      lsp_host_model_i.xfer({m, pay}, rd, st);
      if (m[1]) begin
        chk_byte(rd, m[0] ? tx_data : status);
        chk_bit(st, m[0] & !tx_valid);
      end else begin
        chk_bit(st, m[0] & !rx_ready);
        if (!m[0] || rx_ready) chk_byte(last, pay);
      end
      chk_byte(8'(n_rx), {7'h00, !m[1] & m[0] & rx_ready});
      chk_byte(8'(n_st), {7'h00, !m[1] & !m[0]});
      chk_byte(8'(n_tk), {7'h00, m[1] & m[0] & tx_valid});
      // stale or full answer: repeat the same frame once the source is ready
      if (st === 1'b1) begin
        tx_valid <= 1'b1;
        rx_ready <= 1'b1;
        @(posedge clk_sys_i);
        if (!m[1]) exp_q.push_back(pay);
        lsp_host_model_i.xfer({m, pay}, rd, st);
        chk_bit(st, 1'b0);
        chk_byte(m[1] ? rd : last, m[1] ? tx_data : pay);
        chk_byte(8'(n_rx + n_tk), 8'h01);
      end
    end
    chk_byte(8'(exp_q.size()), 8'h00);
    test_done;
  end
endmodule // tb_lsp_slave
